// *** rtl/ext_bus_pkg.sv ***
package ext_bus_pkg;
  // Oscillator and machine cycle timing
  localparam int unsigned clk_mhz = 100;
  localparam int unsigned osc_per_machine = 6;
  localparam logic [2:0] phase_last = 3'h5;
  localparam logic [2:0] ale_phase = 3'h0;
  localparam logic [2:0] strobe_phase_a = 3'h1;
  localparam logic [2:0] strobe_phase_b = 3'h4;
  localparam logic [2:0] xdata_strobe_phase = 3'h2;
  // Reset needs two whole machine cycles of high reset input
  localparam int unsigned reset_machine_cycles = 2;
  localparam logic [3:0] reset_osc_count = 4'hc;
  // Code space reached externally when strapped low
  localparam logic [15:0] ext_code_lo = 16'h0000;
  localparam logic [15:0] ext_code_hi = 16'h7fff;
  // Pin default values
  localparam logic [7:0] port_reset_value = 8'hff;

  typedef enum logic [1:0] {
    acc_fetch,
    acc_xdata_rd,
    acc_xdata_wr
  } access_type;
endpackage

// *** rtl/machine_phase.sv ***
`timescale 1ns/100ps
// Divides the oscillator into six-phase machine cycles
module machine_phase
  import ext_bus_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_hold,
  output logic [2:0] o_phase,
  output logic o_cycle_end
);
  // Phase counter wraps after the sixth oscillator period
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_phase <= 3'h0;
    end else if (i_hold || o_phase == phase_last) begin
      o_phase <= 3'h0;
    end else begin
      o_phase <= o_phase + 3'h1;
    end
  end

  assign o_cycle_end = (o_phase == phase_last);
endmodule

// *** rtl/ext_bus_pins.sv ***
`timescale 1ns/100ps
// Overview of operation
// - The device resets after its reset pin is high for two machine cycles.
// - After a watchdog overflow the reset pin is driven high during reset.
// - An address latch pulse marks each external fetch address phase.
// - The latch pulse normally recurs at one sixth of the oscillator rate.
// - One latch pulse is dropped in each external data access cycle.
// - External fetch strobes twice a cycle, minus two in a data access.
// - The program-store strobe stays high for internal code fetches.
// - A low access strap at reset sends code 0000H-7FFFH to external memory.
// - A high strap at reset selects internal code; later it is ignored.
// - The upper port carries the high address byte for wide accesses.
// - For byte-pointer data accesses the upper port shows its own latch.
// - Third-port bit 6 is the external data write strobe.
// - Third-port bit 7 is the external data read strobe.
// - Unless emitting an address, a port bit holding one is driven only weakly so it can be an input.
module ext_bus_pins
  import ext_bus_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_reset_pin,
  input wire logic i_wdt_overflow,
  input wire logic i_external_access_sel_n,
  input wire logic i_req,
  input wire logic [1:0] i_req_kind,
  input wire logic i_req_wide,
  input wire logic [15:0] i_req_addr,
  input wire logic [7:0] i_upper_port_out_reg,
  input wire logic [7:0] i_wr_data,
  output logic o_core_reset,
  output logic o_code_external,
  output logic o_busy,
  output logic o_reset_pin_out,
  output logic o_reset_pin_oe_n,
  output logic o_address_latch,
  output logic o_program_store_strobe_n,
  output logic [7:0] o_low_addr_data,
  output logic o_low_oe_n,
  output logic [7:0] o_upper_port,
  output logic [7:0] o_upper_strong_n,
  output logic o_xdata_wr_n,
  output logic o_xdata_rd_n
);
  logic [2:0] phase;
  logic cycle_end;
  logic [3:0] rst_count;
  logic wdt_reset;
  logic strap_taken;
  logic in_reset;
  logic xdata_cycle;
  logic cur_wide;
  logic cur_write;
  logic [15:0] cur_addr;
  logic [7:0] cur_data;
  logic fetch_ext;
  logic phase_hold;

  machine_phase u_phase (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_hold(phase_hold),
    .o_phase(phase),
    .o_cycle_end(cycle_end)
  );

  // Phase runs on in a watchdog reset so that the reset can end
  assign phase_hold = in_reset && !wdt_reset;

  // Reset qualification and watchdog reset
  wire reset_qualified = (rst_count == reset_osc_count);
  wire next_in_reset = reset_qualified || wdt_reset;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_count <= 4'h0;
      wdt_reset <= 1'b0;
      in_reset <= 1'b1;
    end else begin
      if (!i_reset_pin)
        rst_count <= 4'h0;
      else if (!reset_qualified)
        rst_count <= rst_count + 4'h1;
      if (i_wdt_overflow)
        wdt_reset <= 1'b1;
      else if (cycle_end)
        wdt_reset <= 1'b0;
      in_reset <= next_in_reset;
    end
  end

  // Strap sampled while in reset, frozen afterwards
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap_taken <= 1'b1;
    end else if (in_reset) begin
      strap_taken <= i_external_access_sel_n;
    end
  end

  // A data access request is captured at a cycle boundary
  wire start_x = i_req && cycle_end && !in_reset &&
                 (i_req_kind != acc_fetch);
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      xdata_cycle <= 1'b0;
      cur_wide <= 1'b0;
      cur_write <= 1'b0;
      cur_addr <= 16'h0000;
      cur_data <= 8'h00;
    end else if (cycle_end) begin
      xdata_cycle <= start_x;
      cur_wide <= i_req_wide;
      cur_write <= (i_req_kind == acc_xdata_wr);
      cur_addr <= i_req_addr;
      cur_data <= i_wr_data;
    end
  end

  wire code_ext = !strap_taken && (i_req_addr <= ext_code_hi);
  wire next_fetch_ext = i_req && !in_reset && code_ext &&
                        (i_req_kind == acc_fetch);
  wire strobe_slot = (phase == strobe_phase_a) ||
                     (phase == strobe_phase_b);
  wire next_ale = !in_reset && !xdata_cycle && (phase == ale_phase);
  wire next_pss_n = !(fetch_ext && !xdata_cycle && strobe_slot);
  wire x_strobe = xdata_cycle && (phase >= xdata_strobe_phase);
  wire [7:0] next_upper = (xdata_cycle && !cur_wide) ?
                          i_upper_port_out_reg : cur_addr[15:8];

  // Pin outputs, all registered
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fetch_ext <= 1'b0;
      o_core_reset <= 1'b1;
      o_code_external <= 1'b0;
      o_busy <= 1'b0;
      o_reset_pin_out <= 1'b0;
      o_reset_pin_oe_n <= 1'b1;
      o_address_latch <= 1'b0;
      o_program_store_strobe_n <= 1'b1;
      o_low_addr_data <= 8'h00;
      o_low_oe_n <= 1'b1;
      o_upper_port <= port_reset_value;
      o_upper_strong_n <= 8'hff;
      o_xdata_wr_n <= 1'b1;
      o_xdata_rd_n <= 1'b1;
    end else begin
      if (cycle_end)
        fetch_ext <= next_fetch_ext;
      o_core_reset <= next_in_reset;
      o_code_external <= !strap_taken;
      o_busy <= xdata_cycle;
      o_reset_pin_out <= 1'b1;
      o_reset_pin_oe_n <= !wdt_reset;
      o_address_latch <= next_ale;
      o_program_store_strobe_n <= next_pss_n;
      o_low_addr_data <= (x_strobe && cur_write) ? cur_data :
                         cur_addr[7:0];
      o_low_oe_n <= !(xdata_cycle ? cur_write || !x_strobe
                                  : fetch_ext);
      o_upper_port <= next_upper;
      // Strong drive for all upper bits while an address is emitted
      o_upper_strong_n <= ((xdata_cycle && cur_wide) || fetch_ext) ?
                          8'h00 : 8'hff;
      o_xdata_wr_n <= !(x_strobe && cur_write);
      o_xdata_rd_n <= !(x_strobe && !cur_write);
    end
  end

  // Data strobes never overlap
  a_wr_rd_excl: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !(!o_xdata_wr_n && !o_xdata_rd_n))
    else $error("both strobes low");

  // Five quiet samples follow each latch pulse
  sequence s_ale_gap;
    ##1 !o_address_latch [*5];
  endsequence
  a_ale_spacing: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    o_address_latch |-> s_ale_gap)
    else $error("latch pulse too soon");

  // Low address byte stands on the bus during the latch pulse
  a_ale_low_addr: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    o_address_latch |-> o_low_addr_data == $past(cur_addr[7:0]))
    else $error("low byte not on bus");

  // No latch pulse in a data access cycle
  a_skip_in_x: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    $past(xdata_cycle) |-> !o_address_latch)
    else $error("latch during data access");

  // Fetch strobe only in its two slots of a machine cycle
  a_pss_slot: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !o_program_store_strobe_n |-> $past(strobe_slot))
    else $error("strobe outside slot");

  // Fetch strobe stays high for internal code
  a_int_no_strobe: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    $past(!fetch_ext) && !fetch_ext |-> o_program_store_strobe_n)
    else $error("strobe on internal");

  // External fetches put the high address byte on the upper port
  a_wide_port: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    fetch_ext && !xdata_cycle |=> o_upper_port == $past(cur_addr[15:8]))
    else $error("upper port not address");

  // Byte-pointer accesses keep the port latch on the upper port
  a_narrow_port: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    xdata_cycle && !cur_wide |=> o_upper_port == $past(i_upper_port_out_reg))
    else $error("upper port not latch");

  // Reset pin driven high during a watchdog reset
  a_wdt_pin: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    wdt_reset |=> !o_reset_pin_oe_n && o_reset_pin_out)
    else $error("reset pin not driven");

  // Thirteen high samples of the reset pin
  sequence s_pin_held;
    i_reset_pin [*8] ##1 i_reset_pin [*5];
  endsequence
  a_reset_qual: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    s_pin_held |=> o_core_reset)
    else $error("reset not entered");

  // Strap result frozen outside reset
  a_strap_hold: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !in_reset && $past(!in_reset) |-> $stable(strap_taken))
    else $error("strap changed");
endmodule

// *** dv/ext_mem_model.sv ***
`timescale 1ns/100ps
// External address latch beside the low byte bus
module ext_mem_model (
  input wire logic i_ref_clk,
  input wire logic i_address_latch,
  input wire logic [7:0] i_low_addr_data,
  output logic [7:0] o_latched_low
);
  // Capture the low address byte during the latch pulse
  always @(posedge i_ref_clk) begin
    if (i_address_latch === 1'b1) o_latched_low <= i_low_addr_data;
  end
endmodule

// *** dv/ext_bus_pins_tb_top.sv ***
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); \
  err_count++; end end
module ext_bus_pins_tb_top;
  import ext_bus_pkg::*;
  logic i_ref_clk = 0, i_rstn = 0, i_reset_pin = 0, i_wdt_overflow = 0;
  logic i_external_access_sel_n = 1, i_req = 0, i_req_wide = 0;
  logic [1:0] i_req_kind = acc_fetch;
  logic [15:0] i_req_addr = 16'h3c5a;
  logic [7:0] i_upper_port_out_reg = 8'ha5, i_wr_data = 8'h96;
  logic o_core_reset, o_code_external, o_busy, o_reset_pin_out;
  logic o_reset_pin_oe_n, o_address_latch, o_program_store_strobe_n;
  logic o_low_oe_n, o_xdata_wr_n, o_xdata_rd_n;
  logic [7:0] o_low_addr_data, o_upper_port, o_upper_strong_n;
  logic [7:0] latched, up_seen, lo_seen;
  logic oe_seen;
  int err_count = 0, n_tests = 0, cyc = 0, win = 0;
  int n_ale, n_program_store_strobe_n, n_rd, n_wr;
  always #5 i_ref_clk = ~i_ref_clk;
  ext_bus_pins u_dut (.*);
  ext_mem_model u_mem (.i_ref_clk(i_ref_clk),
    .i_address_latch(o_address_latch), .i_low_addr_data(o_low_addr_data),
    .o_latched_low(latched));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Window counters of strobes and the run ceiling
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      conclude();
    end
    if (win > 0) begin
      win <= win - 1;
      n_ale <= n_ale + (o_address_latch === 1'b1);
      n_program_store_strobe_n <= n_program_store_strobe_n + (o_program_store_strobe_n === 1'b0);
      n_rd <= n_rd + (o_xdata_rd_n === 1'b0);
      n_wr <= n_wr + (o_xdata_wr_n === 1'b0);
      if (o_xdata_rd_n === 1'b0 || o_xdata_wr_n === 1'b0) begin
        up_seen <= o_upper_port;
        oe_seen <= o_low_oe_n;
      end
      if (o_xdata_wr_n === 1'b0) lo_seen <= o_low_addr_data;
    end
  end
  // Power reset with the access strap held throughout
  task automatic do_reset(input logic strap);
    i_rstn = 0;
    i_req = 0;
    i_external_access_sel_n = strap;
    repeat (5) @(negedge i_ref_clk);
    i_rstn = 1;
    i_req = 1;
    repeat (12) @(negedge i_ref_clk);
  endtask
  // One data access inside a window of eight machine cycles
  task automatic xfer(input logic [1:0] k, input logic w,
    input logic [7:0] eup, input int ep, input int er, input int ew);
    int t;
    n_ale = 0;
    n_program_store_strobe_n = 0;
    n_rd = 0;
    n_wr = 0;
    win = 48;
    repeat (12) @(negedge i_ref_clk);
    i_req_kind = k;
    i_req_wide = w;
    for (t = 0; t < 12 && o_busy !== 1'b1; t++) @(negedge i_ref_clk);
    i_req_kind = acc_fetch;
    repeat (40) @(negedge i_ref_clk);
    `CHK("ale", 7, n_ale)
    `CHK("program_store_strobe_n", ep, n_program_store_strobe_n)
    `CHK("rd", er, n_rd)
    `CHK("wr", ew, n_wr)
    `CHK("upper", eup, up_seen)
    `CHK("low oe_n", ew == 0, oe_seen)
  endtask
  // Main sequence
  initial begin
    do_reset(1'b1);
    `CHK("code_ext", 1'b0, o_code_external)
    i_external_access_sel_n = 0;
    repeat (12) @(negedge i_ref_clk);
    `CHK("code_ext", 1'b0, o_code_external)
    `CHK("strong_n", 8'hff, o_upper_strong_n)
    xfer(acc_xdata_wr, 1'b0, 8'ha5, 0, 0, 4);
    `CHK("wr data", 8'h96, lo_seen)
    $display("test internal code done");
    do_reset(1'b0);
    `CHK("code_ext", 1'b1, o_code_external)
    xfer(acc_xdata_rd, 1'b1, 8'h3c, 14, 4, 0);
    `CHK("low latch", 8'h5a, latched)
    $display("test external code done");
    i_reset_pin = 1;
    repeat (6) @(negedge i_ref_clk);
    `CHK("short pin", 1'b0, o_core_reset)
    repeat (10) @(negedge i_ref_clk);
    `CHK("long pin", 1'b1, o_core_reset)
    i_reset_pin = 0;
    do_reset(1'b1);
    i_wdt_overflow = 1;
    @(negedge i_ref_clk);
    i_wdt_overflow = 0;
    @(negedge i_ref_clk);
    `CHK("pin oe_n", 1'b0, o_reset_pin_oe_n)
    `CHK("pin out", 1'b1, o_reset_pin_out)
    `CHK("wdt reset", 1'b1, o_core_reset)
    $display("test reset sources done");
    conclude();
  end
endmodule
